// ---- inc/epi_pkg.sv ----
package epi_pkg;
    // Register indices; the byte address is four times the index
    localparam logic [7:0] IDX_MASK_LOW  = 8'h12;
    localparam logic [7:0] IDX_CPU_CTRL  = 8'h35;
    localparam logic [7:0] IDX_EN_MASK   = 8'h3B;
    localparam logic [7:0] IDX_FLAG_BANK = 8'h3A;
    localparam logic [7:0] IDX_MASK_HIGH = 8'h20;
    localparam logic [11:0] ADDR_MASK_LOW  = {2'h0, IDX_MASK_LOW, 2'h0};
    localparam logic [11:0] ADDR_CPU_CTRL  = {2'h0, IDX_CPU_CTRL, 2'h0};
    localparam logic [11:0] ADDR_EN_MASK   = {2'h0, IDX_EN_MASK, 2'h0};
    localparam logic [11:0] ADDR_FLAG_BANK = {2'h0, IDX_FLAG_BANK, 2'h0};
    localparam logic [11:0] ADDR_MASK_HIGH = {2'h0, IDX_MASK_HIGH, 2'h0};

    // Field positions
    localparam int BIT_DED    = 6;
    localparam int BIT_GRP1   = 5;
    localparam int BIT_GRP0   = 4;
    localparam int BIT_SENSE0 = 0;

    // Writable bits of the control, enable and high mask registers
    localparam logic [7:0] WMASK_CPU_CTRL  = 8'h7B;
    localparam logic [7:0] WMASK_EN        = 8'h70;
    localparam logic [7:0] WMASK_HIGH      = 8'h0F;

    // Reset values
    localparam logic [7:0] RST_REG8 = 8'h00;
    localparam logic [1:0] RST_SENSE = 2'h0;

    // Sense modes
    localparam logic [1:0] SENSE_LOW  = 2'h0;
    localparam logic [1:0] SENSE_ANY  = 2'h1;
    localparam logic [1:0] SENSE_FALL = 2'h2;
    localparam logic [1:0] SENSE_RISE = 2'h3;

    // Interrupt request bundle towards the CPU sequencer
    typedef struct packed {
        logic grp1;
        logic grp0;
        logic ded;
    } epi_req_t;
endpackage

// ---- core/epi_top.sv ----
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
// Function
// - Sense field: 00 low level, 01 any change, 10 falling, 11 rising
// - Pin sampled on clock before edge detection; pulses over one clock caught
// - Dedicated request needs enable bit 6 and global flag
// - Pin activity requests even when pin configured as output
// - Group-1 change request on unmasked lines 11..8 with enable bit 5
// - Group-0 change request on unmasked lines 7..0 with enable bit 4
// - Dedicated flag bit 6 sets on edge or change trigger
// - Dedicated flag reads zero while low-level mode selected
// - Group-1 flag bit 5 sets on change of lines 11..8; code also needs enable bit 5 and an unmasked line
// - Group-0 flag bit 4 sets on change of lines 7..0; code also needs enable bit 4 and an unmasked line
// - Set flag plus enable plus global flag branches CPU to vector
// - Hardware clears flag when CPU runs the matching routine
// - Writing one clears a flag, writing zero leaves it
// - High mask bits 3..0 enable lines 11..8 individually
// - Low mask at 0x12, reset zero, enables lines 7..0
// - Reserved bits of mask, flag and high mask read zero
// - Pin-change lines detected without the I/O clock for wake-up
// - Edges need the I/O clock; low level detected asynchronously
// - Low-level request stays asserted while pin held low
module epi_top
    import epi_pkg::*;
(
    // Clock and reset
    input  wire logic             SYS_CLK,
    input  wire logic             SYS_RST,
    // APB slave
    input  wire logic             PSEL,
    input  wire logic             PENABLE,
    input  wire logic             PWRITE,
    input  wire logic [11:0]      PADDR,
    input  wire logic [31:0]      PWDATA,
    output logic      [31:0]      PRDATA,
    output logic                  PREADY,
    output logic                  PSLVERR,
    // External pins (input side of the pad, also valid for outputs)
    input  wire logic             DEDICATED_IRQ_PIN,
    input  wire logic [11:0]      PIN_CHANGE_LINES,
    // CPU interface
    input  wire logic             STATUS_WORD_GLOBAL,
    input  wire epi_pkg::epi_req_t VECTOR_TAKEN,
    output epi_pkg::epi_req_t     IRQ_REQ,
    output logic                  WAKE_REQ
);
    import epi_pkg::*;

    logic [7:0]  cpu_control;
    logic [7:0]  interrupt_enable_mask;
    logic [7:0]  pin_change_mask_low;
    logic [3:0]  pin_change_mask_high;
    logic        dedicated_pin_flag;
    logic        group1_change_flag;
    logic        group0_change_flag;
    logic [12:0] sync1;
    logic [12:0] sync2;
    logic [12:0] prev;
    logic [31:0] rdata;
    epi_req_t    req;

    // Bus decode
    wire         access      = PSEL & PENABLE;
    wire         wr          = access & PWRITE;
    wire         hit_low     = PADDR == ADDR_MASK_LOW;
    wire         hit_ctrl    = PADDR == ADDR_CPU_CTRL;
    wire         hit_en      = PADDR == ADDR_EN_MASK;
    wire         hit_flag    = PADDR == ADDR_FLAG_BANK;
    wire         hit_high    = PADDR == ADDR_MASK_HIGH;
    wire         hit_any     = hit_low | hit_ctrl | hit_en | hit_flag
                               | hit_high;
    wire  [7:0]  wbyte       = PWDATA[7:0];
    wire         wr_flag     = wr & hit_flag;

    // Sense field and derived mode
    wire  [1:0]  sense_select = cpu_control[BIT_SENSE0+1:BIT_SENSE0];
    wire         sense_select_hi = sense_select[1];
    wire         sense_select_lo = sense_select[0];
    wire         low_mode     = sense_select == SENSE_LOW;
    wire         ded_en       = interrupt_enable_mask[BIT_DED];
    wire         group1_change_enable = interrupt_enable_mask[BIT_GRP1];
    wire         group0_change_enable = interrupt_enable_mask[BIT_GRP0];

    // Synchronised pin values and edge terms
    wire         ded_now  = sync2[12];
    wire         ded_prev = prev[12];
    wire         ded_rise = ded_now & ~ded_prev;
    wire         ded_fall = ~ded_now & ded_prev;
    wire         ded_edge = (sense_select_hi & sense_select_lo & ded_rise)
                          | (sense_select_hi & ~sense_select_lo & ded_fall)
                          | (~sense_select_hi & sense_select_lo
                             & (ded_rise | ded_fall));
    wire  [11:0] line_chg = sync2[11:0] ^ prev[11:0];
    wire         chg_grp0 = |(line_chg[7:0] & pin_change_mask_low);
    wire         chg_grp1 = |(line_chg[11:8] & pin_change_mask_high);

    // Asynchronous wake terms, no clock needed
    wire  [11:0] mask_all = {pin_change_mask_high, pin_change_mask_low};
    wire         async_level = low_mode & ded_en & ~DEDICATED_IRQ_PIN;

    // Flag next values: set wins over clear
    wire         next_ded_flag = low_mode ? 1'b0
                 : (ded_edge | (dedicated_pin_flag
                    & ~(wr_flag & wbyte[BIT_DED])
                    & ~VECTOR_TAKEN.ded));
    wire         next_grp1_flag = (chg_grp1 & group1_change_enable)
                 | (group1_change_flag
                    & ~(wr_flag & wbyte[BIT_GRP1])
                    & ~VECTOR_TAKEN.grp1);
    wire         next_grp0_flag = (chg_grp0 & group0_change_enable)
                 | (group0_change_flag
                    & ~(wr_flag & wbyte[BIT_GRP0])
                    & ~VECTOR_TAKEN.grp0);

    // Requests to the CPU sequencer
    assign req.ded  = STATUS_WORD_GLOBAL & ded_en
                      & (low_mode ? ~ded_now : dedicated_pin_flag);
    assign req.grp1 = STATUS_WORD_GLOBAL & group1_change_enable
                      & group1_change_flag;
    assign req.grp0 = STATUS_WORD_GLOBAL & group0_change_enable
                      & group0_change_flag;
    assign IRQ_REQ  = req;

    // Wake request: raw pin against the last sampled value, unclocked
    wire  [11:0] raw_diff = (PIN_CHANGE_LINES ^ prev[11:0]) & mask_all;
    assign WAKE_REQ = async_level
                      | (group0_change_enable & |raw_diff[7:0])
                      | (group1_change_enable & |raw_diff[11:8]);

    // Read mux, reserved bits zero
    wire  [7:0]  flag_rd = {1'b0, dedicated_pin_flag & ~low_mode,
                            group1_change_flag, group0_change_flag, 4'h0};
    always_comb begin
        rdata = 32'h0000_0000;
        if (hit_low) begin
            rdata[7:0] = pin_change_mask_low;
        end else if (hit_ctrl) begin
            rdata[7:0] = cpu_control;
        end else if (hit_en) begin
            rdata[7:0] = interrupt_enable_mask;
        end else if (hit_flag) begin
            rdata[7:0] = flag_rd;
        end else if (hit_high) begin
            rdata[7:0] = {4'h0, pin_change_mask_high};
        end
    end

    assign PREADY  = 1'b1;
    assign PSLVERR = access & ~hit_any;

    // Read data register, loaded in setup so it stands during access
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            PRDATA <= 32'h0000_0000;
        end else if (PSEL & ~PENABLE & ~PWRITE) begin
            PRDATA <= rdata;
        end
    end

    // Control registers
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            cpu_control           <= RST_REG8;
            interrupt_enable_mask <= RST_REG8;
            pin_change_mask_low   <= RST_REG8;
            pin_change_mask_high  <= RST_REG8[3:0];
        end else if (wr) begin
            if (hit_ctrl) begin
                cpu_control <= wbyte & WMASK_CPU_CTRL;
            end
            if (hit_en) begin
                interrupt_enable_mask <= wbyte & WMASK_EN;
            end
            if (hit_low) begin
                pin_change_mask_low <= wbyte;
            end
            if (hit_high) begin
                pin_change_mask_high <= wbyte[3:0];
            end
        end
    end

    // Two-stage synchroniser and previous sample, pins read as inputs
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sync1 <= 13'h0000;
            sync2 <= 13'h0000;
            prev  <= 13'h0000;
        end else begin
            sync1 <= {DEDICATED_IRQ_PIN, PIN_CHANGE_LINES};
            sync2 <= sync1;
            prev  <= sync2;
        end
    end

    // Interrupt flags
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            dedicated_pin_flag <= 1'b0;
            group1_change_flag <= 1'b0;
            group0_change_flag <= 1'b0;
        end else begin
            dedicated_pin_flag <= next_ded_flag;
            group1_change_flag <= next_grp1_flag;
            group0_change_flag <= next_grp0_flag;
        end
    end
endmodule

// ---- bench/epi_checker.sv ----
`timescale 1ns/1ps
module epi_checker
    import epi_pkg::*;
(
    // Clock and reset
    input wire logic              SYS_CLK,
    input wire logic              SYS_RST,
    // Register bus
    input wire logic              PSEL,
    input wire logic              PENABLE,
    input wire logic              PWRITE,
    input wire logic [11:0]       PADDR,
    input wire logic [31:0]       PWDATA,
    input wire logic [31:0]       PRDATA,
    // Pins and CPU side
    input wire logic              DEDICATED_IRQ_PIN,
    input wire logic [11:0]       PIN_CHANGE_LINES,
    input wire logic              STATUS_WORD_GLOBAL,
    input wire epi_pkg::epi_req_t VECTOR_TAKEN,
    input wire epi_pkg::epi_req_t IRQ_REQ
);
    default clocking @(posedge SYS_CLK); endclocking
    default disable iff (SYS_RST);
    logic [7:0]  sns, en, ml, mh;
    wire         wr = PSEL && PENABLE && PWRITE;
    wire         rd = PSEL && PENABLE && !PWRITE;
    wire  [11:0] pc = PIN_CHANGE_LINES;
    // Shadow copies of the control registers
    always_ff @(posedge SYS_CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            {sns, en, ml, mh} <= 32'h0;
        end else if (wr) begin
            if (PADDR == ADDR_CPU_CTRL) sns <= PWDATA[7:0];
            if (PADDR == ADDR_EN_MASK) en <= PWDATA[7:0];
            if (PADDR == ADDR_MASK_LOW) ml <= PWDATA[7:0];
            if (PADDR == ADDR_MASK_HIGH) mh <= PWDATA[7:0];
        end
    end
    // Pins unchanged over the synchroniser depth
    sequence s_quiet;
        $stable(pc) && $past(pc, 2) == pc && $past(pc, 3) == pc;
    endsequence
    sequence s_low;
        sns[1:0] == SENSE_LOW && en[BIT_DED] && STATUS_WORD_GLOBAL
            && !DEDICATED_IRQ_PIN;
    endsequence
    property p_gate; !STATUS_WORD_GLOBAL |-> IRQ_REQ == 3'h0; endproperty
    property p_hi; rd |=> PRDATA[31:8] == 24'h0; endproperty
    property p_dflag;
        rd && PADDR == ADDR_FLAG_BANK && sns[1:0] == SENSE_LOW
            |=> !PRDATA[BIT_DED];
    endproperty
    property p_lvl; s_low [*3] |-> IRQ_REQ.ded; endproperty
    property p_g0;
        STATUS_WORD_GLOBAL && en[BIT_GRP0]
            && ((pc[7:0] ^ $past(pc[7:0])) & ml) != 8'h0
            |-> ##[1:4] IRQ_REQ.grp0;
    endproperty
    property p_g1;
        STATUS_WORD_GLOBAL && en[BIT_GRP1]
            && ((pc[11:8] ^ $past(pc[11:8])) & mh[3:0]) != 4'h0
            |-> ##[1:4] IRQ_REQ.grp1;
    endproperty
    property p_wclr;
        s_quiet ##0 (wr && PADDR == ADDR_FLAG_BANK && PWDATA[BIT_GRP0])
            |=> !IRQ_REQ.grp0;
    endproperty
    property p_vclr; s_quiet ##0 VECTOR_TAKEN.grp1 |=> !IRQ_REQ.grp1; endproperty
    a_gate: assert property (p_gate) else $error("ungated request");
    a_hi: assert property (p_hi) else $error("upper bits set");
    a_dflag: assert property (p_dflag) else $error("flag in level");
    a_lvl: assert property (p_lvl) else $error("level lost");
    a_g0: assert property (p_g0) else $error("group0 missed");
    a_g1: assert property (p_g1) else $error("group1 missed");
    a_wclr: assert property (p_wclr) else $error("flag not cleared");
    a_vclr: assert property (p_vclr) else $error("vector no clear");
endmodule
bind epi_top epi_checker u_chk (.*);

// ---- bench/epi_cpu_model.sv ----
`timescale 1ns/1ps
module epi_cpu_model
    import epi_pkg::*;
(
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              rst,
    // Request and vector side
    input  wire epi_pkg::epi_req_t irq,
    input  wire logic              accept,
    output epi_pkg::epi_req_t      taken
);
    // One-cycle vector pulse, lowest vector first, then a gap cycle
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            taken <= 3'h0;
        end else if (accept && taken == 3'h0) begin
            taken <= irq.ded ? 3'h1 : irq.grp0 ? 3'h2 : {irq.grp1, 2'h0};
        end else begin
            taken <= 3'h0;
        end
    end
endmodule

// ---- bench/epi_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, e) begin compares++; if ((a) !== (e)) begin error_cnt++; \
    $display("BAD t=%0t got=%0h exp=%0h", $time, (a), (e)); end end
module epi_tb_top;
    import epi_pkg::*;
    logic        clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0;
    logic        glob = 0, ded = 1, acc = 0, err, pready, perr, wake;
    logic [11:0] adr = 0, lines = 0;
    logic [31:0] wd = 0, prd;
    logic [7:0]  v;
    epi_req_t    irq, taken;
    int          error_cnt = 0, compares = 0, cyc = 0;

    always #2 clk = ~clk;

    epi_top dut (.SYS_CLK(clk), .SYS_RST(rst), .PSEL(psel), .PENABLE(pen),
        .PWRITE(pwr), .PADDR(adr), .PWDATA(wd), .PRDATA(prd), .PREADY(pready),
        .PSLVERR(perr), .DEDICATED_IRQ_PIN(ded), .PIN_CHANGE_LINES(lines),
        .STATUS_WORD_GLOBAL(glob), .VECTOR_TAKEN(taken), .IRQ_REQ(irq),
        .WAKE_REQ(wake));
    epi_cpu_model cpu (.clk(clk), .rst(rst), .irq(irq), .accept(acc),
        .taken(taken));

    // One transfer: setup cycle, then access until ready
    task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
        @(posedge clk);
        {psel, pen, pwr, adr, wd} <= {2'b10, w, a, 24'h0, d};
        @(posedge clk);
        pen <= 1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        err = perr;
        v = prd[7:0];
        {psel, pen} <= 2'b00;
    endtask
    task rd(input logic [11:0] a, input logic [7:0] e);
        apb(0, a, 8'h00);
        `CHK(v, e)
    endtask
    // Drive pins and global flag, then let the synchronisers settle
    task drv(input logic [11:0] l, input logic d, input logic g);
        @(posedge clk);
        {lines, ded, glob, acc} <= {l, d, g, 1'b0};
        repeat (6) @(posedge clk);
        @(negedge clk);
    endtask
    task t_regs;
        rd(ADDR_MASK_LOW, 8'h00);
        rd(ADDR_CPU_CTRL, 8'h00);
        rd(ADDR_FLAG_BANK, 8'h00);
        apb(1, ADDR_EN_MASK, 8'hFF);
        rd(ADDR_EN_MASK, 8'h70);
        apb(1, ADDR_MASK_HIGH, 8'hFF);
        rd(ADDR_MASK_HIGH, 8'h0F);
        apb(1, 12'hFFC, 8'h5A);
        `CHK(err, 1'b1)
    endtask
    task t_grp;
        drv(12'h000, 1, 1);
        apb(1, ADDR_EN_MASK, 8'h30);
        apb(1, ADDR_MASK_LOW, 8'h01);
        apb(1, ADDR_MASK_HIGH, 8'h08);
        drv(12'h002, 1, 1);
        rd(ADDR_FLAG_BANK, 8'h00);
        drv(12'h003, 1, 1);
        `CHK(irq.grp0, 1'b1)
        rd(ADDR_FLAG_BANK, 8'h10);
        apb(1, ADDR_FLAG_BANK, 8'h00);
        rd(ADDR_FLAG_BANK, 8'h10);
        apb(1, ADDR_FLAG_BANK, 8'h10);
        rd(ADDR_FLAG_BANK, 8'h00);
        drv(12'h403, 1, 1);
        rd(ADDR_FLAG_BANK, 8'h00);
        drv(12'hC03, 1, 1);
        `CHK(irq.grp1, 1'b1)
        rd(ADDR_FLAG_BANK, 8'h20);
        drv(12'hC03, 1, 0);
        `CHK(irq, 3'h0)
        drv(12'hC03, 1, 1);
        `CHK(irq.grp1, 1'b1)
        @(posedge clk);
        acc <= 1;
        drv(12'hC03, 1, 1);
        `CHK(irq.grp1, 1'b0)
        rd(ADDR_FLAG_BANK, 8'h00);
    endtask
    task t_ded;
        apb(1, ADDR_EN_MASK, 8'h40);
        for (int m = 1; m < 4; m++) begin
            apb(1, ADDR_CPU_CTRL, m[7:0]);
            apb(1, ADDR_FLAG_BANK, 8'h40);
            drv(12'hC03, 0, 1);
            rd(ADDR_FLAG_BANK, m == 3 ? 8'h00 : 8'h40);
            apb(1, ADDR_FLAG_BANK, 8'h40);
            drv(12'hC03, 1, 1);
            rd(ADDR_FLAG_BANK, m == 2 ? 8'h00 : 8'h40);
        end
        apb(1, ADDR_CPU_CTRL, 8'h00);
        drv(12'hC03, 0, 1);
        `CHK(irq.ded, 1'b1)
        `CHK(wake, 1'b1)
        rd(ADDR_FLAG_BANK, 8'h00);
        drv(12'hC03, 1, 1);
        `CHK(irq.ded, 1'b0)
        `CHK(wake, 1'b0)
    endtask
    // Print counts and the verdict, then stop
    task summarize;
        $display("Mismatches %0d, comparisons %0d", error_cnt, compares);
        if (error_cnt == 0 && compares > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // Hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 5000) begin
            error_cnt++;
            summarize;
        end
    end
    initial begin
        repeat (3) @(posedge clk);
        rst <= 0;
        t_regs;
        t_grp;
        t_ded;
        summarize;
    end
endmodule
